// >>> rtl/deha_params.svh
// offsets, field positions and reset values of the axis block
`ifndef DEHA_PARAMS_SVH
`define DEHA_PARAMS_SVH
`define DEHA_OFF_CTRL     8'h00
`define DEHA_OFF_ENC_CFG  8'h04
`define DEHA_OFF_AUX_POS  8'h08
`define DEHA_OFF_MAIN_POS 8'h0C
`define DEHA_OFF_GAIN     8'h10
`define DEHA_OFF_SMOOTH   8'h14
`define DEHA_OFF_SPEED    8'h18
`define DEHA_OFF_RATE     8'h1C
`define DEHA_OFF_MOVE     8'h20
`define DEHA_OFF_TARGET   8'h24
`define DEHA_OFF_STATUS   8'h28
`define DEHA_CTRL_STEPPER 0
`define DEHA_CTRL_CIRC    1
`define DEHA_CTRL_DUAL    2
`define DEHA_CTRL_HPOL    3
`define DEHA_MOVE_BEGIN   3
`define DEHA_MOVE_STOP    4
`define DEHA_GAIN_ONE     9'h100
`define DEHA_KS_MIN       9'h001
`define DEHA_RST_SPEED    16'h0100
`define DEHA_RST_RATE     16'h0010
`endif

// >>> rtl/deha_pkg.sv
// types shared by the axis block
package deha_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_MOVE, ST_SEEK, ST_HALT, ST_HM_STOP1,
        ST_HM_BACK, ST_HM_INDEX, ST_HM_STOP3, ST_HM_RET
    } deha_state_t;

    typedef enum logic [2:0] {
        MD_JOG, MD_REL, MD_ABS, MD_VEC, MD_LIN, MD_FE, MD_HM
    } deha_mode_t;

    typedef struct packed {
        logic        stepper;
        logic        circ;
        logic        dual;
        logic        hpol;
        logic [3:0]  enc_cfg;
        logic [7:0]  kp;
        logic [7:0]  ki;
        logic [7:0]  kd;
        logic [8:0]  it;
        logic [8:0]  ks;
        logic [15:0] slew;
        logic [15:0] hspd;
        logic [15:0] acc;
        logic [15:0] dec;
        logic [31:0] target;
        logic [2:0]  mode;
    } deha_regs_t;

    typedef struct packed {
        logic               a_prev;
        logic               b_prev;
        logic signed [31:0] count;
    } deha_enc_t;

    typedef struct packed {
        logic signed [15:0] v;
    } deha_sm_t;

    typedef struct packed {
        deha_regs_t         regs;
        logic [5:0]         s1;
        logic [5:0]         s2;
        logic [5:0]         s3;
        logic [5:0]         filt;
        deha_state_t        state;
        logic signed [15:0] vel_raw;
        logic signed [47:0] pcmd;
        logic signed [31:0] goal;
        logic               fwd;
        logic               home_prev;
        logic               idx_prev;
        logic signed [31:0] idx_pos;
        logic signed [23:0] integ;
        logic signed [31:0] fb_prev;
        logic               step_out;
        logic               dir_out;
        logic signed [15:0] motor_cmd;
        logic               busy;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } deha_axis_t;
endpackage

// >>> rtl/deha_enc_counter.sv
// encoder decoder and position counter, quadrature or pulse and direction
`timescale 1ns/1ps
`include "deha_params.svh"
module deha_enc_counter import deha_pkg::*; (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               enc_a,
    input  wire logic               enc_b,
    input  wire logic [1:0]         code,
    input  wire logic               enable,
    input  wire logic               load,
    input  wire logic signed [31:0] load_val,
    output logic signed [31:0]      count
);
    deha_enc_t r;
    deha_enc_t n;
    logic      moved;
    logic      up;

    always_comb begin
        n = r;
        n.a_prev = enc_a;
        n.b_prev = enc_b;
        if (code[0]) begin
            moved = enc_a & ~r.a_prev;
            up    = enc_b;
        end else begin
            moved = enc_a ^ r.a_prev ^ enc_b ^ r.b_prev;
            up    = enc_a ^ r.b_prev;
        end
        // reversed codes count the other way
        up = up ^ code[1];
        if (load) begin
            n.count = load_val;
        end else if (enable && moved) begin
            n.count = up ? r.count + 32'sd1 : r.count - 32'sd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign count = r.count;
endmodule // deha_enc_counter

// >>> rtl/deha_smoother.sv
// first order velocity smoother, gain 256 passes the input unfiltered
`timescale 1ns/1ps
module deha_smoother import deha_pkg::*; (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic signed [15:0] vel_in,
    input  wire logic [8:0]         gain,
    output logic signed [15:0]      vel_out
);
    deha_sm_t           r;
    deha_sm_t           n;
    logic signed [16:0] diff;
    logic signed [26:0] prod;
    logic signed [16:0] adj;
    logic signed [16:0] sum;

    always_comb begin
        n    = r;
        diff = 17'(vel_in) - 17'(r.v);
        prod = 27'(diff) * 27'($signed({1'b0, gain}));
        adj  = 17'(prod >>> 8);
        // nudge by one so a small gain still settles on the input
        if (adj == 17'sd0 && diff != 17'sd0 && gain != 9'h000) begin
            adj = diff[16] ? -17'sd1 : 17'sd1;
        end
        sum = 17'(r.v) + adj;
        n.v = sum[15:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign vel_out = r.v;
endmodule // deha_smoother

// >>> rtl/deha_axis.sv
// one motion axis: encoders, dual loop filter, smoothing and homing
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "deha_params.svh"
module deha_axis import deha_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        main_a_pin,
    input  wire logic        main_b_pin,
    input  wire logic        index_pin,
    input  wire logic        aux_a_pin,
    input  wire logic        aux_b_pin,
    input  wire logic        home_pin,
    output logic             step_out,
    output logic             dir_out,
    output logic [15:0]      motor_cmd,
    output logic             motion_busy
);
    // =========================================================
    // helpers
    function automatic logic [8:0] clamp9(logic [8:0] v, logic [8:0] lo, logic [8:0] hi);
        if (v < lo) return lo;
        if (v > hi) return hi;
        return v;
    endfunction
    function automatic logic signed [15:0] sat16(logic signed [39:0] v);
        if (v > 40'sd32767) return 16'sh7FFF;
        if (v < -40'sd32768) return 16'sh8000;
        return v[15:0];
    endfunction
    // heavier filtering per doubling of the factor
    function automatic logic [8:0] ks_gain(logic [8:0] f);
        logic [8:0] g;
        g = `DEHA_GAIN_ONE;
        for (int i = 1; i < 9; i++) begin
            if (f >= (9'h001 << i)) g = `DEHA_GAIN_ONE >> i;
        end
        return g;
    endfunction
    function automatic logic signed [15:0] ramp(logic signed [15:0] cur, logic signed [15:0] tgt,
                                                logic [15:0] acc, logic [15:0] dec);
        logic signed [16:0] nx;
        logic [15:0]        st;
        nx = 17'(cur);
        if (cur < tgt) begin
            st = (cur >= 16'sd0) ? acc : dec;
            nx = 17'(cur) + 17'($signed({1'b0, st}));
            if (nx > 17'(tgt)) nx = 17'(tgt);
        end else if (cur > tgt) begin
            st = (cur <= 16'sd0) ? acc : dec;
            nx = 17'(cur) - 17'($signed({1'b0, st}));
            if (nx < 17'(tgt)) nx = 17'(tgt);
        end
        return nx[15:0];
    endfunction
    // =========================================================
    // state and submodules
    deha_axis_t         r;
    deha_axis_t         n;
    logic signed [31:0] main_cnt;
    logic signed [31:0] aux_cnt;
    logic signed [15:0] vel_s;
    logic               aux_on;
    logic               dual_on;
    logic               aux_load;
    logic               main_load;
    logic signed [31:0] main_load_val;
    logic [8:0]         sm_gain;
    assign aux_on  = ~r.regs.stepper & ~r.regs.circ;
    assign dual_on = r.regs.dual & aux_on;
    // stepper factor only steers stepper axes
    assign sm_gain = r.regs.stepper ? ks_gain(r.regs.ks) : r.regs.it;
    deha_enc_counter u_main (
        .pclk     (pclk),
        .presetn  (presetn),
        .enc_a    (r.filt[0]),
        .enc_b    (r.filt[1]),
        .code     (r.regs.enc_cfg[1:0]),
        .enable   (1'b1),
        .load     (main_load),
        .load_val (main_load_val),
        .count    (main_cnt)
    );
    deha_enc_counter u_aux (
        .pclk     (pclk),
        .presetn  (presetn),
        .enc_a    (r.filt[3]),
        .enc_b    (r.filt[4]),
        .code     (r.regs.enc_cfg[3:2]),
        .enable   (aux_on),
        .load     (aux_load),
        .load_val (pwdata),
        .count    (aux_cnt)
    );
    deha_smoother u_sm (
        .pclk    (pclk),
        .presetn (presetn),
        .vel_in  (r.vel_raw),
        .gain    (sm_gain),
        .vel_out (vel_s)
    );
    // =========================================================
    // next state
    logic               acc_ph;
    logic               wr;
    logic               go;
    logic               halt;
    logic               home_lvl;
    logic               toggled;
    logic               stopped;
    logic               reached;
    logic signed [31:0] pint;
    logic signed [15:0] vt;
    logic signed [15:0] slew;
    logic signed [15:0] hv;
    logic signed [31:0] err32;
    logic signed [15:0] err;
    logic signed [31:0] fb;
    logic signed [15:0] dfb;
    logic signed [39:0] ctl;
    logic signed [23:0] isum;
    always_comb begin
        n             = r;
        aux_load      = 1'b0;
        main_load     = 1'b0;
        main_load_val = main_cnt - r.idx_pos;
        go            = 1'b0;
        halt          = 1'b0;
        vt            = 16'sd0;
        reached       = 1'b0;
        pint          = r.pcmd[47:16];
        slew          = $signed(r.regs.slew);
        hv            = $signed(r.regs.hspd);
        // 3-stage sync, change accepted when stages two and three agree
        n.s1   = {home_pin, aux_b_pin, aux_a_pin, index_pin,
                  main_b_pin, main_a_pin};
        n.s2   = r.s1;
        n.s3   = r.s2;
        n.filt = ((r.s2 ~^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.filt);
        home_lvl    = r.filt[5] ^ r.regs.hpol;
        toggled     = home_lvl ^ r.home_prev;
        n.home_prev = home_lvl;
        n.idx_prev  = r.filt[2];
        stopped     = (r.vel_raw == 16'sd0) && (vel_s == 16'sd0);
        // =====================================================
        // apb slave, one wait state
        acc_ph   = psel & penable;
        n.pready = acc_ph & ~r.pready;
        wr       = acc_ph & r.pready & pwrite;
        n.pslverr = 1'b0;
        if (acc_ph && !r.pready) begin
            unique case (paddr)
                `DEHA_OFF_CTRL:     n.prdata = {28'h0, r.regs.hpol, r.regs.dual,
                                                r.regs.circ, r.regs.stepper};
                `DEHA_OFF_ENC_CFG:  n.prdata = {28'h0, r.regs.enc_cfg};
                `DEHA_OFF_AUX_POS:  n.prdata = aux_cnt;
                `DEHA_OFF_MAIN_POS: n.prdata = main_cnt;
                `DEHA_OFF_GAIN:     n.prdata = {8'h0, r.regs.kd, r.regs.ki,
                                                r.regs.kp};
                `DEHA_OFF_SMOOTH:   n.prdata = {7'h0, r.regs.ks, 7'h0, r.regs.it};
                `DEHA_OFF_SPEED:    n.prdata = {r.regs.hspd, r.regs.slew};
                `DEHA_OFF_RATE:     n.prdata = {r.regs.dec, r.regs.acc};
                `DEHA_OFF_MOVE:     n.prdata = {29'h0, r.regs.mode};
                `DEHA_OFF_TARGET:   n.prdata = r.regs.target;
                `DEHA_OFF_STATUS:   n.prdata = {26'h0, home_lvl, r.busy, r.state};
                default: begin
                    n.prdata  = 32'h0;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (wr) begin
            unique case (paddr)
                `DEHA_OFF_CTRL: begin
                    n.regs.stepper = pwdata[`DEHA_CTRL_STEPPER];
                    n.regs.circ    = pwdata[`DEHA_CTRL_CIRC];
                    n.regs.dual    = pwdata[`DEHA_CTRL_DUAL];
                    n.regs.hpol    = pwdata[`DEHA_CTRL_HPOL];
                end
                `DEHA_OFF_ENC_CFG: n.regs.enc_cfg = pwdata[3:0];
                `DEHA_OFF_AUX_POS: aux_load = 1'b1;
                `DEHA_OFF_GAIN: begin
                    n.regs.kp = pwdata[7:0];
                    n.regs.ki = pwdata[15:8];
                    n.regs.kd = pwdata[23:16];
                end
                `DEHA_OFF_SMOOTH: begin
                    n.regs.it = clamp9(pwdata[8:0], 9'h000, `DEHA_GAIN_ONE);
                    n.regs.ks = clamp9(pwdata[24:16], `DEHA_KS_MIN,
                                       `DEHA_GAIN_ONE);
                end
                `DEHA_OFF_SPEED: begin
                    n.regs.slew = pwdata[15:0];
                    n.regs.hspd = pwdata[31:16];
                end
                `DEHA_OFF_RATE: begin
                    n.regs.acc = pwdata[15:0];
                    n.regs.dec = pwdata[31:16];
                end
                `DEHA_OFF_TARGET: n.regs.target = pwdata;
                `DEHA_OFF_MOVE: begin
                    n.regs.mode = pwdata[2:0];
                    go          = pwdata[`DEHA_MOVE_BEGIN];
                    halt        = pwdata[`DEHA_MOVE_STOP];
                end
                default: ;
            endcase
        end
        // =====================================================
        // motion sequencer
        unique case (r.state)
            ST_IDLE: begin
                if (go) begin
                    unique case (deha_mode_t'(n.regs.mode))
                        MD_JOG: n.state = ST_MOVE;
                        MD_FE, MD_HM: begin
                            n.fwd   = ~home_lvl;
                            n.state = ST_SEEK;
                        end
                        MD_ABS: begin
                            n.goal  = n.regs.target;
                            n.fwd   = pint < n.regs.target;
                            n.state = ST_MOVE;
                        end
                        MD_REL, MD_VEC, MD_LIN: begin
                            n.goal  = pint + n.regs.target;
                            n.fwd   = n.regs.target[31] == 1'b0;
                            n.state = ST_MOVE;
                        end
                        default: ;
                    endcase
                end
            end
            ST_MOVE: begin
                if (deha_mode_t'(r.regs.mode) == MD_JOG) begin
                    vt = r.regs.target[31] ? -slew : slew;
                end else begin
                    vt      = r.fwd ? slew : -slew;
                    reached = r.fwd ? (pint >= r.goal) : (pint <= r.goal);
                end
                if (reached) begin
                    n.vel_raw = 16'sd0;
                    n.state   = ST_HALT;
                end
            end
            ST_SEEK: begin
                vt = r.fwd ? slew : -slew;
                if (toggled) begin
                    n.state = (deha_mode_t'(r.regs.mode) == MD_HM) ?
                              ST_HM_STOP1 : ST_HALT;
                end
            end
            ST_HM_STOP1: begin
                if (stopped) n.state = ST_HM_BACK;
            end
            ST_HM_BACK: begin
                vt = r.fwd ? -hv : hv;
                if (toggled) n.state = ST_HM_INDEX;
            end
            ST_HM_INDEX: begin
                // third stage always searches forward
                vt = hv;
                if (r.filt[2] && !r.idx_prev) begin
                    n.idx_pos = main_cnt;
                    n.state   = ST_HM_STOP3;
                end
            end
            ST_HM_STOP3: begin
                if (stopped) begin
                    n.fwd   = main_cnt < r.idx_pos;
                    n.state = ST_HM_RET;
                end
            end
            ST_HM_RET: begin
                vt = r.fwd ? hv : -hv;
                if (r.fwd ? (main_cnt >= r.idx_pos) : (main_cnt <= r.idx_pos)) begin
                    main_load       = 1'b1;
                    n.pcmd[47:16]   = pint - r.idx_pos;
                    n.vel_raw       = 16'sd0;
                    n.state         = ST_HALT;
                end
            end
            ST_HALT: begin
                if (stopped) n.state = ST_IDLE;
            end
        endcase
        if (halt) n.state = ST_HALT;
        if (!reached && !main_load) begin
            n.vel_raw = ramp(r.vel_raw, vt, r.regs.acc, r.regs.dec);
        end
        n.busy = n.state != ST_IDLE;
        // =====================================================
        // profile integration; smoothed velocity drives all moves
        n.pcmd     = n.pcmd + {{32{vel_s[15]}}, vel_s};
        n.step_out = r.regs.stepper && (n.pcmd[16] != r.pcmd[16]);
        n.dir_out  = ~vel_s[15];
        // =====================================================
        // servo filter
        err32 = pint - main_cnt;
        err   = sat16(40'(err32));
        isum  = r.integ + 24'(err);
        if (r.integ[23] == err[15] && isum[23] != r.integ[23]) begin
            isum = r.integ[23] ? 24'sh800000 : 24'sh7FFFFF;
        end
        n.integ = isum;
        // damping from motor side encoder when dual loop is on
        fb        = dual_on ? aux_cnt : main_cnt;
        n.fb_prev = fb;
        dfb       = sat16(40'(fb - r.fb_prev));
        ctl = 40'(err) * 40'($signed({1'b0, r.regs.kp}))
            + ((40'(r.integ) * 40'($signed({1'b0, r.regs.ki}))) >>> 8)
            - 40'(dfb) * 40'($signed({1'b0, r.regs.kd}));
        n.motor_cmd = r.regs.stepper ? 16'sd0 : sat16(ctl);
    end
    // =========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r           <= '0;
            r.regs.it   <= `DEHA_GAIN_ONE;
            r.regs.ks   <= `DEHA_KS_MIN;
            r.regs.slew <= `DEHA_RST_SPEED;
            r.regs.hspd <= `DEHA_RST_SPEED;
            r.regs.acc  <= `DEHA_RST_RATE;
            r.regs.dec  <= `DEHA_RST_RATE;
            r.state     <= ST_IDLE;
        end else begin
            r <= n;
        end
    end
    assign prdata      = r.prdata;
    assign pready      = r.pready;
    assign pslverr     = r.pslverr;
    assign step_out    = r.step_out;
    assign dir_out     = r.dir_out;
    assign motor_cmd   = r.motor_cmd;
    assign motion_busy = r.busy;
endmodule // deha_axis

// >>> test/deha_far_model.sv
// far-side model: main and aux encoders, index pulse and home switch
`timescale 1ns/1ps
module deha_far_model (
    input  wire logic pclk,
    output logic      main_a_pin,
    output logic      main_b_pin,
    output logic      index_pin,
    output logic      aux_a_pin,
    output logic      aux_b_pin,
    output logic      home_pin
);
    logic [1:0] ph [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    initial {main_a_pin, main_b_pin, index_pin, aux_a_pin, aux_b_pin, home_pin} = 6'h00;
    // pins cross a 3-flop sync, so every level is held 6 clocks
    task automatic gap();
        repeat (6) @(posedge pclk);
    endtask
    // one full forward quadrature cycle, ends at 00
    task automatic quad(input bit aux);
        for (int i = 0; i < 4; i++) begin
            if (aux) {aux_a_pin, aux_b_pin} <= ph[i];
            else {main_a_pin, main_b_pin} <= ph[i];
            gap();
        end
    endtask
    // one forward step pulse; dir drops with the pulse, which never counts
    task automatic pulse();
        aux_b_pin <= 1'b1;
        gap();
        aux_a_pin <= 1'b1;
        gap();
        aux_a_pin <= 1'b0;
        aux_b_pin <= 1'b0;
        gap();
    endtask
    task automatic set_home(input logic h);
        home_pin <= h;
        gap();
    endtask
    task automatic index_pulse();
        index_pin <= 1'b1;
        gap();
        index_pin <= 1'b0;
        gap();
    endtask
endmodule // deha_far_model

// >>> test/deha_axis_monitor.sv
// checker for apb timing, step output and motion start of the axis
`timescale 1ns/1ps
`include "deha_params.svh"
module deha_axis_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        step_out,
    input wire logic [15:0] motor_cmd,
    input wire logic        motion_busy
);
    logic stp_q;
    logic bw;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign bw = psel && penable && pready && pwrite && paddr == `DEHA_OFF_MOVE
                && pwdata[`DEHA_MOVE_BEGIN];
    // mirror of the stepper bit, taken at the same edge as the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) stp_q <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == `DEHA_OFF_CTRL)
            stp_q <= pwdata[`DEHA_CTRL_STEPPER];
    end
    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    // ==========================================
    // assertions
    AST_PREADY_WAIT: assert property (s_setup |=> pready) else $error("no single wait");
    AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready held");
    AST_ERR_READY: assert property (pslverr |-> pready) else $error("stray error");
    AST_UNMAPPED: assert property (pready && paddr > 8'h28 |-> pslverr) else $error("no error");
    AST_MAPPED: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped");
    AST_STEP_SERVO: assert property (!stp_q && !$past(stp_q) |-> !step_out)
        else $error("step in servo");
    AST_STEP_PULSE: assert property (step_out |=> !step_out) else $error("step held");
    AST_SERVO_ZERO: assert property (stp_q && $past(stp_q) |-> motor_cmd == 16'h0000)
        else $error("drive in stepper");
    AST_BUSY_CAUSE: assert property ($rose(motion_busy) |-> $past(bw) || $past(bw, 2))
        else $error("busy without begin");
endmodule // deha_axis_monitor
bind deha_axis deha_axis_monitor u_mon (.*);

// >>> test/test_dual_encoder_smoothing_homing_axis.sv
// testbench: axis block over apb with a far-side encoder and switch model
`timescale 1ns/1ps
`include "deha_params.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_dual_encoder_smoothing_homing_axis;
    logic        pclk = 1'b0, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, v;
    logic        pready, pslverr, step_out, dir_out, motion_busy;
    logic        main_a_pin, main_b_pin, index_pin, aux_a_pin, aux_b_pin, home_pin;
    logic [15:0] motor_cmd;
    int          mismatches = 0, tests_run = 0, cyc = 0, steps = 0;
    deha_axis DUT (.*);
    deha_far_model far (.*);
    always #50 pclk = ~pclk;
    // whole run needs about 2k clocks
    always @(posedge pclk) begin
        cyc++;
        steps += step_out;
        if (cyc == 60000) begin
            mismatches++;
            print_verdict();
        end
    end
    // ==========================================
    // bus and helpers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        // ends when pready rises; if it never does, only the bench timeout ends this wait
        do @(posedge pclk); while (pready !== 1'b1);
        v = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_idle();
        while (motion_busy !== 1'b0) @(posedge pclk);
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs();
        apb(0, `DEHA_OFF_SMOOTH, 0);
        `CHK(v, 32'h00010100)
        apb(0, 8'h3C, 0);
        `CHK(v, 32'h00000000)
    endtask
    task automatic t_enc();
        apb(1, `DEHA_OFF_ENC_CFG, 32'h6);
        apb(0, `DEHA_OFF_ENC_CFG, 0);
        `CHK(v[3:0], 4'h6)
        for (int m = 0; m < 3; m += 2) begin
            apb(1, `DEHA_OFF_ENC_CFG, 32'(m));
            far.quad(0);
            apb(0, `DEHA_OFF_MAIN_POS, 0);
            `CHK(v, 32'(m == 0 ? 4 : 0))
        end
        for (int c = 0; c < 4; c++) begin
            apb(1, `DEHA_OFF_ENC_CFG, 32'(c << 2));
            apb(1, `DEHA_OFF_AUX_POS, 32'h0);
            if (c[0]) far.pulse();
            else far.quad(1);
            apb(0, `DEHA_OFF_AUX_POS, 0);
            `CHK(v, 32'((c[0] ? 1 : 4) * (c[1] ? -1 : 1)))
        end
        apb(1, `DEHA_OFF_AUX_POS, 32'h1F4);
        apb(0, `DEHA_OFF_AUX_POS, 0);
        `CHK(v, 32'h1F4)
    endtask
    task automatic t_frozen();
        apb(1, `DEHA_OFF_ENC_CFG, 0);
        apb(1, `DEHA_OFF_AUX_POS, 0);
        for (int m = 1; m < 3; m++) begin
            apb(1, `DEHA_OFF_CTRL, 32'(m));
            far.quad(1);
            apb(0, `DEHA_OFF_AUX_POS, 0);
            `CHK(v, 32'h0)
        end
        apb(1, `DEHA_OFF_CTRL, 32'h1);
        apb(1, `DEHA_OFF_MOVE, 32'h8);
        repeat (800) @(posedge pclk);
        apb(1, `DEHA_OFF_MOVE, 32'h10);
        wait_idle();
        `CHK(steps != 0, 1'b1)
        apb(1, `DEHA_OFF_CTRL, 0);
    endtask
    task automatic t_edge(input logic h, input logic p);
        apb(1, `DEHA_OFF_CTRL, {28'h0, p, 3'b000});
        far.set_home(h);
        apb(1, `DEHA_OFF_RATE, 32'hFFFF0010);
        apb(1, `DEHA_OFF_MOVE, 32'h0D);
        repeat (60) @(posedge pclk);
        `CHK(motion_busy, 1'b1)
        `CHK(dir_out, ~(h ^ p))
        far.set_home(~h);
        wait_idle();
        `CHK(motion_busy, 1'b0)
    endtask
    task automatic t_home();
        apb(1, `DEHA_OFF_CTRL, 0);
        far.set_home(0);
        far.quad(0);
        apb(1, `DEHA_OFF_MOVE, 32'h0E);
        repeat (100) @(posedge pclk);
        far.set_home(1);
        repeat (300) @(posedge pclk);
        far.set_home(0);
        repeat (100) @(posedge pclk);
        far.index_pulse();
        wait_idle();
        apb(0, `DEHA_OFF_MAIN_POS, 0);
        `CHK(v, 32'h0)
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_enc();
        t_frozen();
        t_edge(0, 0);
        t_edge(1, 0);
        t_edge(0, 1);
        t_home();
        print_verdict();
    end
endmodule // test_dual_encoder_smoothing_homing_axis
